// [src/sip_irq_pin.sv]
// Secondary interrupt pulse generator and multifunction pin five multiplexer.
// Assumes synchronous inputs on core_clk_in and a host register port with reads answered next cycle.
//
// Chosen here: strobed register access.
`include "sip_params.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Enabled headset insertion raises secondary interrupt
// - Enabled button press raises secondary interrupt
// - Enabled left/right compressor threshold raises interrupt
// - Enabled left/right AGC noise raises interrupt
// - Enabled headphone over-current raises interrupt
// - Enabled DSP core interrupts raise interrupt
// - Enabled DC measurement ready raises interrupt
// - Pulse control zero gives one 2ms pulse
// - Pulse control one repeats until flags read
// - Reserved registers read zero, writes ignored
// - Codes 0000-0010 disable or make pin input
// - Codes 0011-1010 select pin output source
// - Read-only bit shows live pin level
// - General output drives pin from bit zero
module sip_irq_pin #(
  parameter int PULSE_CYC = `SIP_PULSE_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire sip_pkg::sip_addr_t reg_addr_in,
  input wire sip_pkg::sip_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output sip_pkg::sip_byte_t reg_rdata_out,
  // Event pulses from the codec core
  input wire logic headset_insert_in,
  input wire logic button_press_in,
  input wire logic [1:0] drc_threshold_in,
  input wire logic [1:0] agc_noise_in,
  input wire logic [1:0] hp_overcurrent_in,
  input wire logic [1:0] dsp_irq_in,
  input wire logic [1:0] dc_meas_ready_in,
  // Sources for the pin multiplexer
  input wire logic primary_irq_in,
  input wire logic divided_clock_in,
  input wire logic adc_wclk_in,
  input wire logic sec_bclk_in,
  input wire logic sec_wclk_in,
  input wire logic mic_clk_in,
  // Multifunction pin five
  input wire logic multifunction_pin_five_in,
  output logic multifunction_pin_five_out,
  output logic multifunction_pin_five_oe_out,
  output logic pin_alt_in_out,
  // Interrupts
  output logic secondary_irq_out,
  output logic event_irq_out
);
  import sip_pkg::*;

  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] LAST_CYC = CW'(PULSE_CYC - 1);

  sip_byte_t irq_ctrl_r;
  logic [3:0] pin_func_r;
  logic pin_gpo_r;
  logic [6:0] ev_status_r;
  logic [6:0] ev_status_nxt;
  logic [6:0] ev_enable_r;
  sip_byte_t rdata_r;
  sip_state_e state_r;
  sip_state_e state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic pending_r;
  logic pending_nxt;
  logic pin_out_r;
  logic pin_oe_r;

  function automatic logic hit(input sip_addr_t a, input sip_addr_t off);
    hit = (a == off);
  endfunction

  // Decode
  wire wr_ctrl = reg_wr_in && hit(reg_addr_in, `SIP_OFF_IRQ_CTRL);
  wire wr_pin = reg_wr_in && hit(reg_addr_in, `SIP_OFF_PIN_CTRL);
  wire wr_clr = reg_wr_in && hit(reg_addr_in, `SIP_OFF_EV_CLEAR);
  wire wr_en = reg_wr_in && hit(reg_addr_in, `SIP_OFF_EV_ENABLE);
  // Reading any interrupt flag register stops a pulse train
  wire flag_rd = reg_rd_in && (hit(reg_addr_in, `SIP_OFF_FLAG1)
    || hit(reg_addr_in, `SIP_OFF_FLAG2) || hit(reg_addr_in, `SIP_OFF_FLAG3));

  // Per-source events, each gated by its enable bit
  wire [6:0] ev_raw = {headset_insert_in, button_press_in, |drc_threshold_in,
    |agc_noise_in, |hp_overcurrent_in, |dsp_irq_in, |dc_meas_ready_in};
  wire ev_ins = irq_ctrl_r[`SIP_BIT_INSERT] && ev_raw[6];
  wire ev_btn = irq_ctrl_r[`SIP_BIT_BUTTON] && ev_raw[5];
  wire ev_drc = irq_ctrl_r[`SIP_BIT_DRC] && ev_raw[4];
  wire ev_agc = irq_ctrl_r[`SIP_BIT_AGC] && ev_raw[3];
  wire ev_ovc = irq_ctrl_r[`SIP_BIT_OVC] && ev_raw[2];
  wire ev_dsp = irq_ctrl_r[`SIP_BIT_DSP] && ev_raw[1];
  wire ev_dcm = irq_ctrl_r[`SIP_BIT_DCM] && ev_raw[0];
  wire irq_req = ev_ins | ev_btn | ev_drc | ev_agc | ev_ovc | ev_dsp | ev_dcm;
  wire train = irq_ctrl_r[`SIP_BIT_PULSE];
  wire cnt_done = (cnt_r == LAST_CYC);

  // Pulse sequencer; with the train bit clear a request during a pulse is held and replayed after it
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pending_nxt = pending_r | (irq_req && state_r != SIP_ST_IDLE);
    case (state_r)
      SIP_ST_IDLE: begin
        if (irq_req || pending_r) begin
          state_nxt = SIP_ST_HIGH;
          cnt_nxt = '0;
          pending_nxt = 1'b0;
        end
      end
      SIP_ST_HIGH: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_done) begin
          cnt_nxt = '0;
          state_nxt = train ? SIP_ST_LOW : SIP_ST_IDLE;
        end
      end
      SIP_ST_LOW: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_done) begin
          cnt_nxt = '0;
          state_nxt = SIP_ST_HIGH;
        end
      end
      default: state_nxt = SIP_ST_IDLE;
    endcase
    // Flag read ends the train at once
    if (flag_rd && train) begin
      state_nxt = SIP_ST_IDLE;
      cnt_nxt = '0;
      pending_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= SIP_ST_IDLE;
      cnt_r <= '0;
      pending_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pending_r <= pending_nxt;
    end
  end

  wire sec_irq = (state_r == SIP_ST_HIGH);

  // Control registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_ctrl_r <= `SIP_IRQ_CTRL_RST;
      pin_func_r <= `SIP_PIN_FUNC_RST;
      pin_gpo_r <= 1'b0;
      ev_enable_r <= '0;
    end else begin
      if (wr_ctrl) irq_ctrl_r <= reg_wdata_in;
      if (wr_pin) begin
        pin_func_r <= reg_wdata_in[`SIP_PIN_FUNC_LSB +: 4];
        pin_gpo_r <= reg_wdata_in[`SIP_PIN_GPO_BIT];
      end
      if (wr_en) ev_enable_r <= reg_wdata_in[6:0];
    end
  end

  // Sticky event status; a new event wins over a clear in the same cycle
  // Only raw source events are recorded; pulse activity must not alias a source bit
  wire [6:0] ev_seen = ev_raw;
  assign ev_status_nxt = (ev_status_r & ~(wr_clr ? reg_wdata_in[6:0] : 7'h00)) | ev_seen;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) ev_status_r <= '0;
    else ev_status_r <= ev_status_nxt;
  end

  // Pin multiplexer
  sip_func_e fn;
  assign fn = sip_func_e'(pin_func_r);
  logic mux_out;
  logic mux_oe;
  always_comb begin
    mux_oe = 1'b1;
    mux_out = 1'b0;
    case (fn)
      SIP_FN_GPO: mux_out = pin_gpo_r;
      SIP_FN_DIVIDED_CLOCK_OUTPUT: mux_out = divided_clock_in;
      SIP_FN_PRI_IRQ: mux_out = primary_irq_in;
      SIP_FN_SEC_IRQ: mux_out = sec_irq;
      SIP_FN_ADC_WCLK: mux_out = adc_wclk_in;
      SIP_FN_SEC_BCLK: mux_out = sec_bclk_in;
      SIP_FN_SEC_WCLK: mux_out = sec_wclk_in;
      SIP_FN_MIC_CLK: mux_out = mic_clk_in;
      // Off, input modes and reserved codes leave the pin undriven
      default: mux_oe = 1'b0;
    endcase
  end
  wire pin_in_en = (fn == SIP_FN_ALT_IN) || (fn == SIP_FN_GPI);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_out_r <= mux_out;
      pin_oe_r <= mux_oe;
    end
  end

  // Read data; unmapped and reserved addresses return zero
  wire sip_byte_t pin_rd = {2'b00, pin_func_r, multifunction_pin_five_in, pin_gpo_r};
  sip_byte_t rd_mux;
  always_comb begin
    if (hit(reg_addr_in, `SIP_OFF_IRQ_CTRL)) rd_mux = irq_ctrl_r;
    else if (hit(reg_addr_in, `SIP_OFF_PIN_CTRL)) rd_mux = pin_rd;
    else if (hit(reg_addr_in, `SIP_OFF_EV_STATUS)) rd_mux = {1'b0, ev_status_r};
    else if (hit(reg_addr_in, `SIP_OFF_EV_ENABLE)) rd_mux = {1'b0, ev_enable_r};
    else rd_mux = 8'h00;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) rdata_r <= 8'h00;
    else if (reg_rd_in) rdata_r <= rd_mux;
    else rdata_r <= 8'h00;
  end

  assign reg_rdata_out = rdata_r;
  assign secondary_irq_out = sec_irq;
  assign multifunction_pin_five_out = pin_out_r;
  assign multifunction_pin_five_oe_out = pin_oe_r;
  assign pin_alt_in_out = pin_in_en && (fn == SIP_FN_ALT_IN) && multifunction_pin_five_in;
  assign event_irq_out = |(ev_status_r & ev_enable_r);
endmodule
`default_nettype wire

// [src/sip_params.svh]
// Register offsets, field positions and timing for the secondary interrupt and pin block.
// Included by the package and the design; definitions only.
`ifndef SIP_PARAMS_SVH
`define SIP_PARAMS_SVH
`define SIP_ADDR_W 8
`define SIP_OFF_IRQ_CTRL 8'h31
`define SIP_OFF_RSVD0 8'h32
`define SIP_OFF_RSVD1 8'h33
`define SIP_OFF_PIN_CTRL 8'h34
`define SIP_OFF_FLAG1 8'h2a
`define SIP_OFF_FLAG2 8'h2c
`define SIP_OFF_FLAG3 8'h2d
`define SIP_OFF_EV_STATUS 8'h40
`define SIP_OFF_EV_CLEAR 8'h41
`define SIP_OFF_EV_ENABLE 8'h42
`define SIP_IRQ_CTRL_RST 8'h00
`define SIP_PIN_FUNC_RST 4'h0
`define SIP_BIT_INSERT 7
`define SIP_BIT_BUTTON 6
`define SIP_BIT_DRC 5
`define SIP_BIT_AGC 4
`define SIP_BIT_OVC 3
`define SIP_BIT_DSP 2
`define SIP_BIT_DCM 1
`define SIP_BIT_PULSE 0
`define SIP_PIN_FUNC_LSB 2
`define SIP_PIN_IN_BIT 1
`define SIP_PIN_GPO_BIT 0
`define SIP_PULSE_NS 2000000
`define SIP_CLK_NS 4
`define SIP_PULSE_CYC (`SIP_PULSE_NS / `SIP_CLK_NS)
`endif

// [src/sip_pkg.sv]
// Types for the secondary interrupt and pin block.
// Assumes sip_params.svh is on the include path.
`include "sip_params.svh"
package sip_pkg;
  typedef logic [`SIP_ADDR_W-1:0] sip_addr_t;
  typedef logic [7:0] sip_byte_t;
  typedef enum logic [3:0] {
    SIP_FN_OFF = 4'h0,
    SIP_FN_ALT_IN = 4'h1,
    SIP_FN_GPI = 4'h2,
    SIP_FN_GPO = 4'h3,
    SIP_FN_DIVIDED_CLOCK_OUTPUT = 4'h4,
    SIP_FN_PRI_IRQ = 4'h5,
    SIP_FN_SEC_IRQ = 4'h6,
    SIP_FN_ADC_WCLK = 4'h7,
    SIP_FN_SEC_BCLK = 4'h8,
    SIP_FN_SEC_WCLK = 4'h9,
    SIP_FN_MIC_CLK = 4'ha
  } sip_func_e;
  typedef enum logic [1:0] {
    SIP_ST_IDLE = 2'b00,
    SIP_ST_HIGH = 2'b01,
    SIP_ST_LOW = 2'b11
  } sip_state_e;
endpackage

// [test/sip_chk.sv]
// Port-level checks for the secondary interrupt and pin block.
// Bound to sip_irq_pin; shadows the control registers from bus writes.
`include "sip_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sip_chk #(
  parameter int PULSE_CYC = 8
) (
  input wire logic core_clk_in, arst_n_in, reg_wr_in, reg_rd_in,
  input wire sip_pkg::sip_addr_t reg_addr_in,
  input wire sip_pkg::sip_byte_t reg_wdata_in, reg_rdata_out,
  input wire logic headset_insert_in, button_press_in, primary_irq_in,
  input wire logic [1:0] drc_threshold_in, agc_noise_in, hp_overcurrent_in,
  input wire logic [1:0] dsp_irq_in, dc_meas_ready_in,
  input wire logic multifunction_pin_five_in, multifunction_pin_five_out,
  input wire logic multifunction_pin_five_oe_out, pin_alt_in_out, secondary_irq_out
);
  import sip_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sip_byte_t ctrl_r, pin_r;
  int hi_cnt_r;
  wire logic [3:0] fn = pin_r[5:2];
  wire logic flag_rd = reg_rd_in && (reg_addr_in inside {8'h2a, 8'h2c, 8'h2d});
  wire logic ev_en = ctrl_r[7] & headset_insert_in | ctrl_r[6] & button_press_in
    | ctrl_r[5] & |drc_threshold_in | ctrl_r[4] & |agc_noise_in
    | ctrl_r[3] & |hp_overcurrent_in | ctrl_r[2] & |dsp_irq_in | ctrl_r[1] & |dc_meas_ready_in;
  // Shadows track the design's registers edge for edge
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= 8'h00;
      pin_r <= 8'h00;
      hi_cnt_r <= 0;
    end else begin
      if (reg_wr_in && reg_addr_in == `SIP_OFF_IRQ_CTRL) ctrl_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `SIP_OFF_PIN_CTRL) pin_r <= reg_wdata_in;
      hi_cnt_r <= secondary_irq_out ? hi_cnt_r + 1 : 0;
    end
  end
  property p_rsvd;
    $past(reg_rd_in) && $past(reg_addr_in) inside {8'h32, 8'h33} |-> reg_rdata_out == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_gpo;
    fn == 4'h3 && $stable(pin_r) |-> multifunction_pin_five_oe_out
      && multifunction_pin_five_out == pin_r[0];
  endproperty
  a_gpo: assert property (p_gpo) else $error("general output level wrong");
  property p_in_off;
    fn <= 4'h2 && $stable(pin_r) |-> !multifunction_pin_five_oe_out;
  endproperty
  a_in_off: assert property (p_in_off) else $error("pin driven in input mode");
  property p_alt;
    fn == 4'h1 |-> pin_alt_in_out == multifunction_pin_five_in;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate input not forwarded");
  property p_route;
    fn inside {4'h5, 4'h6} && $stable(pin_r) |-> multifunction_pin_five_oe_out
      && multifunction_pin_five_out == (fn == 4'h5 ? $past(primary_irq_in) : $past(secondary_irq_out));
  endproperty
  a_route: assert property (p_route) else $error("interrupt routing wrong");
  property p_len;
    !ctrl_r[0] && $fell(secondary_irq_out) |-> hi_cnt_r == PULSE_CYC;
  endproperty
  a_len: assert property (p_len) else $error("pulse length wrong");
  property p_stop;
    ctrl_r[0] && flag_rd |=> !secondary_irq_out;
  endproperty
  a_stop: assert property (p_stop) else $error("train not stopped");
  property p_raise;
    !ctrl_r[0] && ev_en && !secondary_irq_out |=> secondary_irq_out;
  endproperty
  a_raise: assert property (p_raise) else $error("enabled event missed");
  property p_quiet;
    !ctrl_r[0] && !ev_en && !secondary_irq_out && !$past(secondary_irq_out)
      |=> !secondary_irq_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt without enabled event");
endmodule
`default_nettype wire

// [test/sip_host_model.sv]
// Host side of the pin: resolves the wire, host drives it when released.
// Assumes the host holds a defined level; no floating pin.
`timescale 1ns/1ps
`default_nettype none
module sip_host_model (
  input wire logic pin_out_in,
  input wire logic pin_oe_in,
  input wire logic ext_level_in,
  output logic pin_level_out
);
  assign pin_level_out = pin_oe_in ? pin_out_in : ext_level_in;
endmodule
`default_nettype wire

// [test/sip_irq_pin_bench.sv]
// Self-checking bench for sip_irq_pin over its register port.
// Assumes the package, header and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sip_irq_pin_bench;
  import sip_pkg::*;
  localparam int PC = 8;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic wr = 1'b0, rd = 1'b0, sd = 1'b0, ext_lvl = 1'b1;
  sip_addr_t addr = 8'h00;
  sip_byte_t wd = 8'h00, v;
  sip_addr_t ra[3] = '{8'h32, 8'h33, 8'h50};
  logic [7:1] ev = 7'h00;
  logic [5:0] src = 6'h00;
  wire sip_byte_t rdata;
  wire logic pin_out, pin_oe, pin_lvl, alt, sec_irq, evt_irq;
  int bad_count = 0, n_tests = 0, n;
  always #2 core_clk_in = ~core_clk_in;
  sip_irq_pin #(.PULSE_CYC(PC)) DUT (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .headset_insert_in(ev[7]), .button_press_in(ev[6]), .drc_threshold_in({ev[5]&sd, ev[5]&~sd}),
    .agc_noise_in({ev[4]&sd, ev[4]&~sd}), .hp_overcurrent_in({ev[3]&sd, ev[3]&~sd}),
    .dsp_irq_in({ev[2]&sd, ev[2]&~sd}), .dc_meas_ready_in({ev[1]&sd, ev[1]&~sd}),
    .divided_clock_in(src[0]), .primary_irq_in(src[1]), .adc_wclk_in(src[2]),
    .sec_bclk_in(src[3]), .sec_wclk_in(src[4]), .mic_clk_in(src[5]),
    .multifunction_pin_five_in(pin_lvl), .multifunction_pin_five_out(pin_out),
    .multifunction_pin_five_oe_out(pin_oe), .pin_alt_in_out(alt),
    .secondary_irq_out(sec_irq), .event_irq_out(evt_irq));
  sip_host_model u_host (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_level_in(ext_lvl),
    .pin_level_out(pin_lvl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wreg(input sip_addr_t a, input sip_byte_t d);
    @(posedge core_clk_in);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input sip_addr_t a);
    @(posedge core_clk_in);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic fire(input int i);
    @(posedge core_clk_in);
    ev[i] <= 1'b1; sd <= i[0];
    cyc(1);
    ev <= 7'h00;
  endtask
  // Counts cycles the interrupt holds a level, bounded against hangs
  task automatic run(input logic lv);
    n = 0;
    while (sec_irq === lv && n < 100) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rreg(8'h31); chk(v, 8'h00);
    rreg(8'h34); chk(v, 8'h02);
    foreach (ra[k]) begin
      rreg(ra[k]); chk(v, 8'h00);
    end
    $display("register reset test done");
    for (int i = 1; i < 8; i++) begin
      wreg(8'h31, 8'h01 << i);
      fire(i); run(1'b1); chk(n, PC);
      wreg(8'h31, ~(8'h01 << i) & 8'hfe);
      fire(i); cyc(2); chk(sec_irq, 1'b0);
    end
    $display("event enable test done");
    wreg(8'h31, 8'h81);
    fire(7); run(1'b1); chk(n, PC);
    run(1'b0); chk(n, PC);
    rreg(8'h2c); chk(sec_irq, 1'b0);
    cyc(2 * PC); chk(sec_irq, 1'b0);
    wreg(8'h31, 8'h00);
    $display("pulse train test done");
    wreg(8'h41, 8'h7f); wreg(8'h42, 8'h40);
    fire(7); cyc(2); chk(evt_irq, 1'b1);
    rreg(8'h40); chk(v, 8'h40);
    wreg(8'h41, 8'h40); cyc(2); chk(evt_irq, 1'b0);
    wreg(8'h42, 8'h00); fire(7); cyc(2); chk(evt_irq, 1'b0);
    rreg(8'h40); chk(v, 8'h40);
    $display("event status test done");
    for (int p = 0; p < 2; p++) begin
      src <= p ? 6'h2d : 6'h12;
      for (int c = 0; c < 11; c++) begin
        wreg(8'h34, {2'b00, c[3:0], 2'b01});
        cyc(2); chk(pin_oe, c > 2);
        if (c > 2) chk(pin_out, c == 3 ? 1'b1 : c == 6 ? 1'b0 : src[c < 6 ? c - 4 : c - 5]);
      end
    end
    wreg(8'h34, 8'h0c); cyc(2); chk(pin_out, 1'b0);
    for (int lv = 0; lv < 2; lv++) begin
      ext_lvl <= lv[0];
      wreg(8'h34, 8'h04); cyc(1); chk(alt, lv[0]);
      wreg(8'h34, 8'h08); rreg(8'h34); chk(v, {4'h2, lv[0], 1'b0});
    end
    $display("pin function test done");
    tally_and_finish;
  end
  // Run needs under 400 cycles; far beyond that means a hang
  initial begin
    #20000;
    bad_count++;
    tally_and_finish;
  end
endmodule
bind sip_irq_pin sip_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .headset_insert_in(headset_insert_in), .button_press_in(button_press_in),
  .primary_irq_in(primary_irq_in), .drc_threshold_in(drc_threshold_in),
  .agc_noise_in(agc_noise_in), .hp_overcurrent_in(hp_overcurrent_in), .dsp_irq_in(dsp_irq_in),
  .dc_meas_ready_in(dc_meas_ready_in), .multifunction_pin_five_in(multifunction_pin_five_in),
  .multifunction_pin_five_out(multifunction_pin_five_out),
  .multifunction_pin_five_oe_out(multifunction_pin_five_oe_out),
  .pin_alt_in_out(pin_alt_in_out), .secondary_irq_out(secondary_irq_out));
`default_nettype wire
